// File: rtl/dpc_pin_stage.sv
// Output register stage that drives one memory port's pins from the sequencer.
`timescale 1ns/1ps
`default_nettype none
module dpc_pin_stage
    import dpc_pkg::*;
(
    // Clock and reset.
    input  wire logic              mclk_i,
    input  wire logic              rst_n_i,
    // Drive from the sequencer.
    dpc_pins_if.dst                pins,
    // Memory port pins.
    output var  logic              ce_n_o,
    output var  logic              rw_n_o,
    output var  logic              oe_n_o,
    output var  logic              semaphore_select_n_o,
    output var  logic              upper_byte_select_n_o,
    output var  logic              lower_byte_select_n_o,
    output var  logic [ADDR_W-1:0] addr_o,
    output var  logic [DATA_W-1:0] data_o,
    output var  logic              data_oe_o
);

    // All pin state kept in one register so every pin switches on the same edge.
    typedef struct packed {
        logic              ce_n;
        logic              rw_n;
        logic              oe_n;
        logic              sem_n;
        logic              bytes_n;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
        logic              data_oe;
    } dpc_pin_state_t;

    dpc_pin_state_t st_reg;   // Registered pin state.
    dpc_pin_state_t st_next;  // Next pin state.

    // Copy the sequencer drive; registering avoids glitches on the strobes.
    always_comb begin
        st_next         = st_reg;
        st_next.ce_n    = pins.sel_n;
        st_next.rw_n    = pins.rw_n;
        st_next.oe_n    = pins.oe_n;
        st_next.sem_n   = pins.sem_n;
        st_next.bytes_n = pins.bytes_n;
        st_next.addr    = pins.addr;
        st_next.data    = pins.wdata;
        st_next.data_oe = pins.drive;
    end

    // Reset parks every select inactive and the data bus released.
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_reg <= '{ce_n: 1'b1, rw_n: 1'b1, oe_n: 1'b1, sem_n: 1'b1,
                        bytes_n: 1'b1, addr: '0, data: '0, data_oe: 1'b0};
        end else begin
            st_reg <= st_next;
        end
    end

    assign ce_n_o                = st_reg.ce_n;
    assign rw_n_o                = st_reg.rw_n;
    assign oe_n_o                = st_reg.oe_n;
    assign semaphore_select_n_o  = st_reg.sem_n;
    assign upper_byte_select_n_o = st_reg.bytes_n;
    assign lower_byte_select_n_o = st_reg.bytes_n;
    assign addr_o                = st_reg.addr;
    assign data_o                = st_reg.data;
    assign data_oe_o             = st_reg.data_oe;

endmodule
`default_nettype wire

// File: rtl/dpc_pins_if.sv
// Interface carrying the drive of one memory port from the sequencer to the pin stage.
`timescale 1ns/1ps
`default_nettype none
interface dpc_pins_if;
    import dpc_pkg::*;
    logic              sel_n;     // Chip select, active low.
    logic              rw_n;      // Write strobe, low writes.
    logic              oe_n;      // Output enable, active low.
    logic              sem_n;     // Semaphore select, active low.
    logic              bytes_n;   // Both byte selects, active low.
    logic [ADDR_W-1:0] addr;      // Address.
    logic [DATA_W-1:0] wdata;     // Write data.
    logic              drive;     // Host drives the data lines.
    modport src (output sel_n, rw_n, oe_n, sem_n, bytes_n, addr, wdata, drive);
    modport dst (input  sel_n, rw_n, oe_n, sem_n, bytes_n, addr, wdata, drive);
endinterface
`default_nettype wire

// File: rtl/dpc_pkg.sv
// Package of constants, types and timing counts for the dual-port memory port controller.
package dpc_pkg;

    // Pin widths of one memory port.
    localparam int ADDR_W = 16;
    localparam int DATA_W = 18;

    // Mailbox addresses of the two ports.
    localparam logic [ADDR_W-1:0] MBOX_LEFT_ADDR  = 16'hFFFE;
    localparam logic [ADDR_W-1:0] MBOX_RIGHT_ADDR = 16'hFFFF;

    // Semaphore request and release values on data bit zero.
    localparam logic SEM_REQUEST = 1'b0;
    localparam logic SEM_RELEASE = 1'b1;
    localparam int   SEM_BIT     = 0;

    // Clock period and timing figures of the slower grade, in nanoseconds.
    localparam int CLK_PERIOD_NS   = 10;
    localparam int ENABLE_WRITE_NS = 15;  // Select to end of write.
    localparam int WRITE_PULSE_NS  = 15;  // Least strobe width.
    localparam int OUT_OFF_NS      = 10;  // Output off after strobe falls.
    localparam int DATA_SETUP_NS   = 15;  // Data valid to end of write.
    localparam int WRITE_HOLD_NS   = 15;  // write_hold_after_collision.
    localparam int READ_ACCESS_NS  = 20;  // Access time of a read.
    localparam int PORT_DELAY_NS   = 45;  // Write pulse to far-side data.

    // Round a least time up to whole cycles, never below one.
    function automatic int ns_to_cyc(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction

    // Cycle counts derived from the figures above.
    localparam int WP_OE_NS      = (OUT_OFF_NS + DATA_SETUP_NS > WRITE_PULSE_NS)
                                   ? OUT_OFF_NS + DATA_SETUP_NS : WRITE_PULSE_NS;
    localparam int WP_CYC        = ns_to_cyc(WRITE_PULSE_NS);
    localparam int WP_OE_CYC     = ns_to_cyc(WP_OE_NS);
    localparam int EW_CYC        = ns_to_cyc(ENABLE_WRITE_NS);
    localparam int WH_CYC        = ns_to_cyc(WRITE_HOLD_NS);
    localparam int RD_CYC        = ns_to_cyc(READ_ACCESS_NS);
    localparam int PD_CYC        = ns_to_cyc(PORT_DELAY_NS);
    localparam int CNT_W         = 4;

    // Kinds of access that the user side can ask for.
    typedef enum logic [1:0] {
        DPC_OP_RD     = 2'b00,
        DPC_OP_WR     = 2'b01,
        DPC_OP_SEM_RD = 2'b10,
        DPC_OP_SEM_WR = 2'b11
    } dpc_op_t;

endpackage

// File: rtl/dpc_port_ctrl.sv
// Host-side controller that runs reads, writes and semaphore accesses on one memory port.
`timescale 1ns/1ps
`default_nettype none
module dpc_port_ctrl
    import dpc_pkg::*;
(
    // Clock and reset.
    input  wire logic              mclk_i,
    input  wire logic              arst_n_i,
    // User request side.
    input  wire logic              req_valid_i,
    output logic                   req_ready_o,
    input  wire dpc_op_t           req_op_i,
    input  wire logic [ADDR_W-1:0] req_addr_i,
    input  wire logic [DATA_W-1:0] req_wdata_i,
    // User answer side.
    output var  logic              rsp_valid_o,
    output var  logic [DATA_W-1:0] rsp_rdata_o,
    output var  logic              rsp_sem_owned_o,
    // Mailbox and collision flags from the memory port.
    input  wire logic              busy_n_i,
    input  wire logic              int_n_i,
    output var  logic              mbox_pending_o,
    // Memory port pins.
    output var  logic              ce_n_o,
    output var  logic              rw_n_o,
    output var  logic              oe_n_o,
    output var  logic              semaphore_select_n_o,
    output var  logic              upper_byte_select_n_o,
    output var  logic              lower_byte_select_n_o,
    output var  logic [ADDR_W-1:0] addr_o,
    output var  logic [DATA_W-1:0] data_o,
    output var  logic              data_oe_o,
    input  wire logic [DATA_W-1:0] data_i
);

    // Sequencer states.
    typedef enum logic [2:0] {
        DPC_IDLE   = 3'b000,
        DPC_SETUP  = 3'b001,
        DPC_STROBE = 3'b010,
        DPC_HOLD   = 3'b011,
        DPC_READ   = 3'b100,
        DPC_DONE   = 3'b101
    } dpc_state_t;

    // Whole controller state in one struct.
    typedef struct packed {
        dpc_state_t        state;
        dpc_op_t           op;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic [CNT_W-1:0]  cnt;
        logic              rsp_valid;
        logic [DATA_W-1:0] rdata;
        logic              sem_owned;
    } dpc_ctrl_t;

    dpc_ctrl_t  c_reg;        // Registered state.
    dpc_ctrl_t  c_next;       // Next state.
    logic       rst_s1_reg;   // Reset release, first stage.
    logic       rst_n_reg;    // Reset release, second stage, used everywhere.
    logic       is_sem;       // Current access targets a semaphore.
    logic       is_wr;        // Current access writes.

    dpc_pins_if pins ();

    // Release the asynchronous reset through two flip-flops.
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rst_s1_reg <= 1'b0;
            rst_n_reg  <= 1'b0;
        end else begin
            rst_s1_reg <= 1'b1;
            rst_n_reg  <= rst_s1_reg;
        end
    end

    // Operation code bit one selects the semaphore, bit zero a write.
    assign is_sem = c_reg.op[1];
    assign is_wr  = c_reg.op[0];

    // Truncate a cycle count to the counter width.
    function automatic logic [CNT_W-1:0] cyc(input int n);
        return CNT_W'(n);
    endfunction

    // Sequencer: setup with strobes idle, strobe, then hold on writes or read sample on reads.
    always_comb begin
        c_next           = c_reg;
        c_next.rsp_valid = 1'b0;
        unique case (c_reg.state)
            DPC_IDLE: begin
                // Address is latched only while every strobe is idle.
                if (req_valid_i) begin
                    c_next.op    = req_op_i;
                    c_next.addr  = req_addr_i;
                    c_next.wdata = req_wdata_i;
                    c_next.cnt   = '0;
                    c_next.state = DPC_SETUP;
                end
            end
            DPC_SETUP: begin
                // One cycle of address setup before any select falls.
                c_next.cnt   = '0;
                c_next.state = DPC_STROBE;
            end
            DPC_STROBE: begin
                c_next.cnt = c_reg.cnt + cyc(1);
                if (is_wr) begin
                    // Pulse length rule.
                    // Output enable is held high on writes, so the plain pulse suffices.
                    if (c_reg.cnt + cyc(1) >= cyc((WP_CYC > EW_CYC) ? WP_CYC : EW_CYC)) begin
                        // Wait on collision.
                        // A low collision flag means our write is parked inside the device.
                        if (busy_n_i) begin
                            c_next.state = DPC_HOLD;
                            c_next.cnt   = '0;
                        end
                    end
                end else if (c_reg.cnt + cyc(1) >= cyc(RD_CYC)) begin
                    c_next.state = DPC_READ;
                end
            end
            DPC_HOLD: begin
                // Hold after flag.
                // Keep the strobe low after the flag rises so the deferred write lands.
                c_next.cnt = c_reg.cnt + cyc(1);
                if (!busy_n_i) begin
                    c_next.cnt = '0;
                end else if (c_reg.cnt + cyc(1) >= cyc(WH_CYC)) begin
                    c_next.state = DPC_DONE;
                end
            end
            DPC_READ: begin
                // Read after release.
                // A read that met a collision waits out the far write before sampling.
                if (busy_n_i) begin
                    c_next.rdata = data_i;
                    // Semaphore readback.
                    // Bit zero carries the semaphore; all lines show the same value.
                    if (is_sem) begin
                        c_next.sem_owned = (data_i[SEM_BIT] == SEM_REQUEST);
                    end
                    c_next.state = DPC_DONE;
                end
            end
            DPC_DONE: begin
                // Strobes are idle here, giving write recovery before the next access.
                c_next.rsp_valid = 1'b1;
                c_next.state     = DPC_IDLE;
            end
            default: begin
                c_next.state = DPC_IDLE;
            end
        endcase
    end

    // State register.
    always_ff @(posedge mclk_i or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            c_reg <= '{state: DPC_IDLE, op: DPC_OP_RD, addr: '0, wdata: '0,
                       cnt: '0, rsp_valid: 1'b0, rdata: '0, sem_owned: 1'b0};
        end else begin
            c_reg <= c_next;
        end
    end

    // Drive for the pin stage.
    always_comb begin
        pins.sel_n   = 1'b1;
        pins.rw_n    = 1'b1;
        pins.oe_n    = 1'b1;
        pins.sem_n   = 1'b1;
        pins.bytes_n = 1'b1;
        pins.addr    = c_reg.addr;
        pins.drive   = 1'b0;
        // Semaphore write data.
        // Semaphore writes carry the request or release on data bit zero.
        pins.wdata   = c_reg.wdata;
        if (c_reg.state == DPC_STROBE || c_reg.state == DPC_HOLD ||
            c_reg.state == DPC_READ) begin
            // Exclusive select.
            // Array uses chip select; semaphore uses its own select with chip select high.
            pins.sel_n   = is_sem;
            pins.sem_n   = !is_sem;
            pins.bytes_n = 1'b0;
            pins.rw_n    = !is_wr;
            pins.oe_n    = is_wr;
            pins.drive   = is_wr;
        end
    end

    dpc_pin_stage u_pins (
        .mclk_i                (mclk_i),
        .rst_n_i               (rst_n_reg),
        .pins                  (pins),
        .ce_n_o                (ce_n_o),
        .rw_n_o                (rw_n_o),
        .oe_n_o                (oe_n_o),
        .semaphore_select_n_o  (semaphore_select_n_o),
        .upper_byte_select_n_o (upper_byte_select_n_o),
        .lower_byte_select_n_o (lower_byte_select_n_o),
        .addr_o                (addr_o),
        .data_o                (data_o),
        .data_oe_o             (data_oe_o)
    );

    // Requests are refused until the reset copy is released; a request taken while
    // the state register is still held would be lost and never answered.
    assign req_ready_o     = rst_n_reg && (c_reg.state == DPC_IDLE);
    // Answer outputs come straight from the state register.
    assign rsp_valid_o     = c_reg.rsp_valid;
    assign rsp_rdata_o     = c_reg.rdata;
    assign rsp_sem_owned_o = c_reg.sem_owned;
    // The mailbox flag passes through; the memory clears it when we read the mailbox.
    assign mbox_pending_o  = !int_n_i;

endmodule
`default_nettype wire

// File: verification/dpc_asserts.sv
// Checker of the port controller's pin and handshake behaviour.
`timescale 1ns/1ps
`default_nettype none
module dpc_asserts
    import dpc_pkg::*;
(
    // Clock and reset.
    input  wire logic              mclk_i,
    input  wire logic              arst_n_i,
    // Handshake.
    input  wire logic              req_valid_i,
    input  wire logic              req_ready_o,
    input  wire logic              rsp_valid_o,
    // Flags.
    input  wire logic              busy_n_i,
    input  wire logic              int_n_i,
    input  wire logic              mbox_pending_o,
    // Memory port pins.
    input  wire logic              ce_n_o,
    input  wire logic              rw_n_o,
    input  wire logic              oe_n_o,
    input  wire logic              semaphore_select_n_o,
    input  wire logic              upper_byte_select_n_o,
    input  wire logic              lower_byte_select_n_o,
    input  wire logic [ADDR_W-1:0] addr_o,
    input  wire logic [DATA_W-1:0] data_o,
    input  wire logic              data_oe_o
);
    // One clock domain, so clock and reset are given once.
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!arst_n_i);
    sequence taken_s;
        req_valid_i && req_ready_o;
    endsequence
    sel_excl_a: assert property (ce_n_o || semaphore_select_n_o)
        else $error("Array and semaphore selected together.");
    wr_sel_a: assert property (!rw_n_o |-> ce_n_o != semaphore_select_n_o)
        else $error("Strobe low without exactly one select.");
    oe_wr_a: assert property (!rw_n_o |-> oe_n_o)
        else $error("Output enable low during a write.");
    drive_a: assert property (data_oe_o |-> oe_n_o)
        else $error("Host drives data while memory outputs enabled.");
    strobe_hold_a: assert property (!rw_n_o && !$past(rw_n_o)
        |-> $stable(addr_o) && $stable(data_o))
        else $error("Address or data moved inside a strobe.");
    bytes_a: assert property (upper_byte_select_n_o == lower_byte_select_n_o)
        else $error("Byte selects differ.");
    wp_width_a: assert property ($fell(rw_n_o) |-> !rw_n_o [*2])
        else $error("Write pulse too short.");
    busy_hold_a: assert property ($rose(busy_n_i) && !rw_n_o |-> !rw_n_o [*2])
        else $error("Strobe released too soon after busy.");
    rsp_lat_a: assert property (taken_s |=> !rsp_valid_o [*4] ##[1:60] rsp_valid_o)
        else $error("Answer outside its window.");
    mbox_a: assert property (mbox_pending_o == !int_n_i)
        else $error("Mailbox pending does not follow the flag.");
    // Main scenarios.
    cover property ($rose(busy_n_i) && !rw_n_o);
    cover property (!semaphore_select_n_o && !rw_n_o);
    cover property ($rose(int_n_i));
endmodule
bind dpc_port_ctrl dpc_asserts chk_u (.mclk_i, .arst_n_i, .req_valid_i, .req_ready_o,
    .rsp_valid_o, .busy_n_i, .int_n_i, .mbox_pending_o, .ce_n_o, .rw_n_o, .oe_n_o,
    .semaphore_select_n_o, .upper_byte_select_n_o, .lower_byte_select_n_o, .addr_o,
    .data_o, .data_oe_o);
`default_nettype wire

// File: verification/dpc_dev_model.sv
// Behavioural model of one port of the two-port memory, seen from the host.
`timescale 1ns/1ps
`default_nettype none
module dpc_dev_model
    import dpc_pkg::*;
(
    // Sampling clock and pins from the host.
    input  wire logic              mclk_i,
    input  wire logic              ce_n_i,
    input  wire logic              rw_n_i,
    input  wire logic              oe_n_i,
    input  wire logic              sem_n_i,
    input  wire logic              ub_n_i,
    input  wire logic              lb_n_i,
    input  wire logic [ADDR_W-1:0] addr_i,
    input  wire logic [DATA_W-1:0] wd_i,
    input  wire logic              wd_oe_i,
    input  wire logic              busy_n_i,
    // Resolved data lines and mailbox flag.
    output logic      [DATA_W-1:0] dq_o,
    output logic                   int_n_o
);
    logic [DATA_W-1:0] mem [0:65535]; // Array contents.
    logic [1:0]        sem_st [0:7];  // 0 free, 1 this port, 2 far port.
    logic [7:0]        pend = 8'h00;  // Far port waits for a semaphore.
    logic [DATA_W-1:0] last = '0;     // Last level seen on the lines.
    logic              far_int_n = 1'b1;
    // Array accesses need both byte selects, so a host that leaves them high fails.
    wire bytes_on = !ub_n_i && !lb_n_i;
    // Writes need select and strobe together and no busy.
    wire arr_wr = !rw_n_i && !ce_n_i && sem_n_i && busy_n_i && bytes_on;
    wire sem_wr = !rw_n_i && !sem_n_i && ce_n_i && busy_n_i;
    wire rd_en  = rw_n_i && !oe_n_i && ((!ce_n_i && bytes_on) || !sem_n_i);
    initial begin
        int_n_o = 1'b1;
        for (int i = 0; i < 8; i++) sem_st[i] = 2'd0;
    end
    // Undriven lines show the inverse of the last level.
    always_comb begin
        if (wd_oe_i) dq_o = wd_i;
        else if (rd_en && !sem_n_i) dq_o = {DATA_W{sem_st[addr_i[2:0]] != 2'd1}};
        else if (rd_en) dq_o = mem[addr_i];
        else dq_o = ~last;
    end
    // State changes at each sampled edge.
    always @(posedge mclk_i) begin
        last <= dq_o;
        if (arr_wr) mem[addr_i] <= wd_i;
        if (arr_wr && addr_i == MBOX_RIGHT_ADDR) far_int_n <= 1'b0;
        if (rd_en && sem_n_i && addr_i == MBOX_LEFT_ADDR) int_n_o <= 1'b1;
        if (sem_wr && wd_i[SEM_BIT] == SEM_REQUEST && sem_st[addr_i[2:0]] == 2'd0)
            sem_st[addr_i[2:0]] <= 2'd1;
        if (sem_wr && wd_i[SEM_BIT] == SEM_RELEASE && sem_st[addr_i[2:0]] == 2'd1)
            sem_st[addr_i[2:0]] <= pend[addr_i[2:0]] ? 2'd2 : 2'd0;
    end
endmodule
`default_nettype wire

// File: verification/tb_top.sv
// Self-checking testbench of the port controller against the memory model.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import dpc_pkg::*;
    logic mclk_i, arst_n_i, req_valid, busy_n;
    dpc_op_t req_op;
    logic [ADDR_W-1:0] req_addr, addr;
    logic [DATA_W-1:0] req_wdata, rdata, dout, dq;
    logic ready, rsp_valid, owned, mbox, int_n, ce_n, rw_n, oe_n, sem_n, ub_n, lb_n, d_oe;
    int err_total = 0;
    int total_checks = 0;
    int cyc;
    dpc_port_ctrl dut_u (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .req_valid_i(req_valid),
        .req_ready_o(ready), .req_op_i(req_op), .req_addr_i(req_addr),
        .req_wdata_i(req_wdata), .rsp_valid_o(rsp_valid), .rsp_rdata_o(rdata),
        .rsp_sem_owned_o(owned), .busy_n_i(busy_n), .int_n_i(int_n), .mbox_pending_o(mbox),
        .ce_n_o(ce_n), .rw_n_o(rw_n), .oe_n_o(oe_n), .semaphore_select_n_o(sem_n),
        .upper_byte_select_n_o(ub_n), .lower_byte_select_n_o(lb_n), .addr_o(addr),
        .data_o(dout), .data_oe_o(d_oe), .data_i(dq));
    dpc_dev_model dev_u (.mclk_i(mclk_i), .ce_n_i(ce_n), .rw_n_i(rw_n), .oe_n_i(oe_n),
        .sem_n_i(sem_n), .ub_n_i(ub_n), .lb_n_i(lb_n), .addr_i(addr), .wd_i(dout),
        .wd_oe_i(d_oe), .busy_n_i(busy_n),
        .dq_o(dq), .int_n_o(int_n));
    // Free-running clock.
    initial begin
        mclk_i = 1'b0;
        forever #5 mclk_i = ~mclk_i;
    end
    // Compare one value and count it.
    task automatic chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_sim;
        if (err_total == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // One request, raised for one cycle once ready is seen (or after 50 cycles), then a bounded wait for the answer.
    task automatic xfer(input dpc_op_t op, input logic [15:0] a, input logic [17:0] d);
        int n;
        n = 0;
        while (ready !== 1'b1 && n < 50) begin
            @(posedge mclk_i);
            #1 n++;
        end
        req_op = op;
        req_addr = a;
        req_wdata = d;
        req_valid = 1'b1;
        @(posedge mclk_i);
        #1 req_valid = 1'b0;
        cyc = 1;
        while (rsp_valid !== 1'b1 && cyc < 100) begin
            @(posedge mclk_i);
            #1 cyc++;
        end
        if (cyc >= 100) chk(18'h0_0000, 18'h0_0001);
    endtask
    // Back-to-back writes, then reads of both places.
    task automatic t_rw;
        xfer(DPC_OP_WR, 16'h0012, 18'h2_A5C3);
        xfer(DPC_OP_WR, 16'h0013, 18'h1_5A3C);
        chk(dev_u.mem[16'h0012], 18'h2_A5C3);
        xfer(DPC_OP_RD, 16'h0013, 18'h0_0000);
        chk(rdata, 18'h1_5A3C);
        xfer(DPC_OP_RD, 16'h0012, 18'h0_0000);
        chk(rdata, 18'h2_A5C3);
    endtask
    // Write and read stalled by a collision flag held low for 10 cycles.
    task automatic t_busy(input dpc_op_t op);
        busy_n = 1'b0;
        fork
            begin
                repeat (10) @(posedge mclk_i);
                #1 busy_n = 1'b1;
            end
        join_none
        xfer(op, 16'h0012, 18'h3_0F0F);
        chk({17'h0_0000, cyc > 10}, 18'h0_0001);
        chk(op == DPC_OP_WR ? dev_u.mem[16'h0012] : rdata, 18'h3_0F0F);
    endtask
    // Semaphore grant, read-back, refusal and hand-over.
    task automatic t_sem;
        xfer(DPC_OP_SEM_WR, 16'h0003, 18'h0_0000);
        xfer(DPC_OP_SEM_RD, 16'h0003, 18'h0_0000);
        chk(rdata, 18'h0_0000);
        chk({17'h0_0000, owned}, 18'h0_0001);
        dev_u.sem_st[5] = 2'd2;
        xfer(DPC_OP_SEM_WR, 16'h0005, 18'h0_0000);
        xfer(DPC_OP_SEM_RD, 16'h0005, 18'h0_0000);
        chk(rdata, 18'h3_FFFF);
        chk({17'h0_0000, owned}, 18'h0_0000);
        dev_u.pend[3] = 1'b1;
        xfer(DPC_OP_SEM_WR, 16'h0003, 18'h0_0001);
        chk({16'h0000, dev_u.sem_st[3]}, 18'h0_0002);
    endtask
    // Mailbox flag raised by the far port, cleared by our read.
    task automatic t_mbox;
        @(posedge mclk_i);
        #1 dev_u.int_n_o = 1'b0;
        @(posedge mclk_i);
        #1 chk({17'h0_0000, mbox}, 18'h0_0001);
        xfer(DPC_OP_RD, MBOX_LEFT_ADDR, 18'h0_0000);
        chk({17'h0_0000, mbox}, 18'h0_0000);
        xfer(DPC_OP_WR, MBOX_RIGHT_ADDR, 18'h0_0077);
        chk({17'h0_0000, dev_u.far_int_n}, 18'h0_0000);
    endtask
    // Watchdog sized well past the expected hundred or so cycles.
    initial begin
        #200000;
        err_total++;
        end_sim();
    end
    // Reset for six cycles, then the scenarios.
    initial begin
        arst_n_i = 1'b0;
        req_valid = 1'b0;
        req_op = DPC_OP_RD;
        req_addr = '0;
        req_wdata = '0;
        busy_n = 1'b1;
        repeat (6) @(posedge mclk_i);
        #1 arst_n_i = 1'b1;
        t_rw();
        t_busy(DPC_OP_WR);
        t_busy(DPC_OP_RD);
        t_sem();
        t_mbox();
        end_sim();
    end
endmodule
`default_nettype wire
